// ---- rtl/bpic_pkg.sv ----
// Notes on behaviour
// - Channel enable setting, enabled after reset.
// - Static or pulse-rate type, static default.
// - Static type reports the switch on/off state.
// - Selectable active polarity, high by default.
// - Pulse rate becomes a continuously updated value.
// - Maximum frequency 100.00 to 1000.00 Hz, default top.
// - Rates above the maximum are clamped to the maximum.
// - Frequency, parameter or flow mode; frequency default.
// - Name and unit texts, 16 characters each.
// - Lower range value -2000.00 to 0.00 at 0 Hz.
// - Upper range value 0.00 to 10000.00 at maximum.
// - Moving-average damping 0 to 60 s, default none.
// - Selectable decimal places for the value.
// - Inactive process-access input holds off sampling.
package bpic_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ       = 100;     // System clock rate
  localparam int GATE_TIME_MS  = 1000;    // Counting gate, one second
  localparam int GATE_CYCLES   = GATE_TIME_MS * CLK_MHZ * 1000;
  localparam logic [5:0]  DIV_STEPS   = 6'h30;  // One quotient bit a cycle
  localparam logic [39:0] HZ_TO_CENTI = 40'h64; // Hz to hundredths

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_FMAX   = 8'h04;
  localparam logic [7:0] OFS_LRV    = 8'h08;
  localparam logic [7:0] OFS_URV    = 8'h0C;
  localparam logic [7:0] OFS_DAMP   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_FREQ   = 8'h18;
  localparam logic [7:0] OFS_VALUE  = 8'h1C;
  localparam logic [7:0] OFS_NAME   = 8'h20;  // Four words of text
  localparam logic [7:0] OFS_UNIT   = 8'h30;  // Four words of text

  // ==========================================================
  // Control and status word fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_TYPE_BIT = 1;
  localparam int CTRL_POL_BIT  = 2;
  localparam int CTRL_MODE_LSB = 4;   // Two bits
  localparam int CTRL_DEC_LSB  = 8;   // Two bits
  localparam int STAT_ACT_BIT  = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_VAL_BIT  = 2;

  // ==========================================================
  // Reset values and limits (values in hundredths)
  localparam logic        RST_EN   = 1'b1;
  localparam logic        RST_POL  = 1'b1;
  localparam logic [1:0]  RST_DEC  = 2'h2;
  localparam logic [31:0] FMAX_MIN = 32'h0000_2710;
  localparam logic [31:0] FMAX_MAX = 32'h0001_86A0;
  localparam logic [31:0] LRV_MIN  = 32'hFFFC_F2C0;  // -2000.00
  localparam logic [31:0] URV_MAX  = 32'h000F_4240;  // 10000.00
  localparam logic [31:0] RST_RNG  = 32'h0000_0000;
  localparam logic [5:0]  DAMP_MAX = 6'h3C;
  localparam logic [5:0]  RST_DAMP = 6'h00;

  // ==========================================================
  // Types
  typedef enum logic {SIG_STATIC, SIG_PULSE} bpic_sig_type;
  typedef enum logic [1:0] {
    MODE_FREQ, MODE_PARAM, MODE_FLOW
  } bpic_mode_type;
  typedef enum logic [1:0] {
    FSM_IDLE, FSM_SCALE, FSM_DAMP, FSM_AVG
  } bpic_fsm_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } bpic_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } bpic_apb_rsp_type;

  typedef struct packed {
    logic          en;
    bpic_sig_type  sig;
    logic          pol;
    bpic_mode_type mode;
    logic [1:0]    dec;
    logic [31:0]   fmax;
    logic [31:0]   lrv;
    logic [31:0]   urv;
    logic [5:0]    damp;
  } bpic_cfg_type;

  typedef struct packed {
    bpic_cfg_type      cfg;
    logic [3:0][31:0]  name;
    logic [3:0][31:0]  unit;
    bpic_apb_rsp_type  rsp;
    logic              pin;
    logic              active;
    logic              hold;
    logic [26:0]       gate;
    logic [26:0]       edges;
    logic [31:0]       freq;
    logic [31:0]       scaled;
    logic [31:0]       value;
    logic              valid;
    bpic_fsm_type      fsm;
    logic [63:0][31:0] hist;
    logic [5:0]        wp;
    logic [5:0]        fill;
    logic [39:0]       sum;
    logic              neg;
    logic              div_go;
    logic [47:0]       dvd;
    logic [31:0]       dsr;
  } bpic_state_type;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [31:0] rem;
    logic [47:0] quo;
    logic [31:0] dsr;
  } bpic_div_state_type;

endpackage : bpic_pkg

// ---- rtl/bpic_divider.sv ----
`timescale 1ns/100ps
// ==========================================================
// Sequential restoring divider, one quotient bit per cycle
module bpic_divider (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic [47:0] dividend,
  input  wire logic [31:0] divisor,
  output logic             done,
  output logic [47:0]      quotient
);

  bpic_pkg::bpic_div_state_type s_q;    // All divider state
  bpic_pkg::bpic_div_state_type s_d;    // Its next value
  logic [32:0]                  trial;  // Shifted partial remainder

  // Next state: shift, trial subtract, restore
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    trial    = {s_q.rem, s_q.quo[47]};
    if (start) begin
      // Divisor is never zero: callers keep it at one or above
      s_d.busy = 1'b1;
      s_d.cnt  = bpic_pkg::DIV_STEPS;
      s_d.rem  = '0;
      s_d.quo  = dividend;
      s_d.dsr  = divisor;
    end else if (s_q.busy) begin
      if (trial >= {1'b0, s_q.dsr}) begin
        s_d.rem = 32'(trial - {1'b0, s_q.dsr});
        s_d.quo = {s_q.quo[46:0], 1'b1};
      end else begin
        s_d.rem = trial[31:0];
        s_d.quo = {s_q.quo[46:0], 1'b0};
      end
      s_d.cnt = 6'(s_q.cnt - 6'h01);
      if (s_q.cnt == 6'h01) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign done     = s_q.done;
  assign quotient = s_q.quo;

endmodule : bpic_divider

// ---- rtl/bpic_channel.sv ----
`timescale 1ns/100ps
// ==========================================================
// Binary input channel: static level or pulse-rate readout
module bpic_channel #(
  parameter int GATE_CYCLES = bpic_pkg::GATE_CYCLES
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  input  wire logic                       clk_en,
  input  wire bpic_pkg::bpic_apb_req_type apb_req,
  output bpic_pkg::bpic_apb_rsp_type      apb_rsp,
  input  wire logic                       pin_in,
  output logic                            level_active_q,
  output logic                            sample_hold_q,
  output logic [31:0]                     value_q,
  output logic                            value_valid_q,
  output logic [1:0]                      value_decimals_q
);

  bpic_pkg::bpic_state_type s_q;      // All channel state
  bpic_pkg::bpic_state_type s_d;      // Its next value
  logic        hit;                   // Address is mapped
  logic [31:0] rd_word;               // Read mux result
  logic        wr;                    // Write completes this edge
  logic        pulse_on;              // Pulse-rate counting runs
  logic        gate_end;              // Last cycle of a gate
  logic [39:0] freq_raw;              // Counted rate, hundredths
  logic [31:0] freq_c;                // Rate clamped to maximum
  logic [31:0] span;                  // Upper minus lower value
  logic [31:0] old;                   // Sample leaving the window
  logic [39:0] sum_n;                 // Updated window sum
  logic        div_done;              // Divider finished
  logic [47:0] div_q;                 // Divider quotient

  // ==========================================================
  // Shared divider: scaling and averaging take turns
  bpic_divider u_div (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .start    (s_q.div_go),
    .dividend (s_q.dvd),
    .divisor  (s_q.dsr),
    .done     (div_done),
    .quotient (div_q)
  );

  // ==========================================================
  // Register read mux
  always_comb begin
    hit     = 1'b1;
    rd_word = '0;
    unique case (apb_req.paddr)
      bpic_pkg::OFS_CTRL: begin
        rd_word[bpic_pkg::CTRL_EN_BIT]   = s_q.cfg.en;
        rd_word[bpic_pkg::CTRL_TYPE_BIT] = s_q.cfg.sig;
        rd_word[bpic_pkg::CTRL_POL_BIT]  = s_q.cfg.pol;
        rd_word[bpic_pkg::CTRL_MODE_LSB +: 2] = s_q.cfg.mode;
        rd_word[bpic_pkg::CTRL_DEC_LSB +: 2]  = s_q.cfg.dec;
      end
      bpic_pkg::OFS_FMAX: rd_word = s_q.cfg.fmax;
      bpic_pkg::OFS_LRV:  rd_word = s_q.cfg.lrv;
      bpic_pkg::OFS_URV:  rd_word = s_q.cfg.urv;
      bpic_pkg::OFS_DAMP: rd_word[5:0] = s_q.cfg.damp;
      bpic_pkg::OFS_STATUS: begin
        // Live state of the channel for software
        rd_word[bpic_pkg::STAT_ACT_BIT]  = s_q.active;
        rd_word[bpic_pkg::STAT_HOLD_BIT] = s_q.hold;
        rd_word[bpic_pkg::STAT_VAL_BIT]  = s_q.valid;
      end
      bpic_pkg::OFS_FREQ:  rd_word = s_q.freq;
      bpic_pkg::OFS_VALUE: rd_word = s_q.value;
      default: begin
        // Text words, else unmapped
        if (apb_req.paddr[7:4] == bpic_pkg::OFS_NAME[7:4]) begin
          rd_word = s_q.name[apb_req.paddr[3:2]];
        end else if (apb_req.paddr[7:4] == bpic_pkg::OFS_UNIT[7:4]) begin
          rd_word = s_q.unit[apb_req.paddr[3:2]];
        end else begin
          hit = 1'b0;
        end
        if (apb_req.paddr[1:0] != 2'h0) begin
          hit = 1'b0;
        end
      end
    endcase
  end

  // Write strobe and arithmetic helpers for the pulse path
  assign wr       = apb_req.psel && apb_req.penable && apb_req.pwrite &&
                    s_q.rsp.pready && hit;
  assign pulse_on = s_q.cfg.en && (s_q.cfg.sig == bpic_pkg::SIG_PULSE);
  assign gate_end = pulse_on && (s_q.gate == 27'(GATE_CYCLES - 1));
  assign freq_raw = 40'(s_q.edges) * bpic_pkg::HZ_TO_CENTI;
  assign freq_c   = (freq_raw > {8'h00, s_q.cfg.fmax}) ? s_q.cfg.fmax
                                                      : freq_raw[31:0];
  assign span     = 32'(s_q.cfg.urv - s_q.cfg.lrv);
  assign old      = s_q.hist[6'(s_q.wp - s_q.cfg.damp)];
  assign sum_n    = (s_q.fill == s_q.cfg.damp)
                  ? 40'($signed(s_q.sum) + $signed(s_q.scaled)
                        - $signed(old))
                  : 40'($signed(s_q.sum) + $signed(s_q.scaled));

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_d        = s_q;
    s_d.div_go = 1'b0;

    // APB slave: one wait state, answer registered
    s_d.rsp.pready = 1'b0;
    if (apb_req.psel && apb_req.penable && !s_q.rsp.pready) begin
      s_d.rsp.pready  = 1'b1;
      s_d.rsp.pslverr = !hit;
      s_d.rsp.prdata  = apb_req.pwrite ? '0 : rd_word;
    end

    // Register writes, out-of-range values clamped
    if (wr) begin
      unique case (apb_req.paddr)
        bpic_pkg::OFS_CTRL: begin
          s_d.cfg.en  = apb_req.pwdata[bpic_pkg::CTRL_EN_BIT];
          s_d.cfg.sig = bpic_pkg::bpic_sig_type'(
                          apb_req.pwdata[bpic_pkg::CTRL_TYPE_BIT]);
          s_d.cfg.pol = apb_req.pwdata[bpic_pkg::CTRL_POL_BIT];
          s_d.cfg.dec = apb_req.pwdata[bpic_pkg::CTRL_DEC_LSB +: 2];
          // Code three is no mode: old mode kept
          if (apb_req.pwdata[bpic_pkg::CTRL_MODE_LSB +: 2] != 2'h3) begin
            s_d.cfg.mode = bpic_pkg::bpic_mode_type'(
                        apb_req.pwdata[bpic_pkg::CTRL_MODE_LSB +: 2]);
          end
        end
        bpic_pkg::OFS_FMAX: begin
          if (apb_req.pwdata < bpic_pkg::FMAX_MIN) begin
            s_d.cfg.fmax = bpic_pkg::FMAX_MIN;
          end else if (apb_req.pwdata > bpic_pkg::FMAX_MAX) begin
            s_d.cfg.fmax = bpic_pkg::FMAX_MAX;
          end else begin
            s_d.cfg.fmax = apb_req.pwdata;
          end
        end
        bpic_pkg::OFS_LRV: begin
          if ($signed(apb_req.pwdata) < $signed(bpic_pkg::LRV_MIN)) begin
            s_d.cfg.lrv = bpic_pkg::LRV_MIN;
          end else if (apb_req.pwdata[31]) begin
            s_d.cfg.lrv = apb_req.pwdata;
          end else begin
            s_d.cfg.lrv = bpic_pkg::RST_RNG;
          end
        end
        bpic_pkg::OFS_URV: begin
          if (apb_req.pwdata[31]) begin
            s_d.cfg.urv = bpic_pkg::RST_RNG;
          end else if (apb_req.pwdata > bpic_pkg::URV_MAX) begin
            s_d.cfg.urv = bpic_pkg::URV_MAX;
          end else begin
            s_d.cfg.urv = apb_req.pwdata;
          end
        end
        bpic_pkg::OFS_DAMP: begin
          if (apb_req.pwdata > 32'(bpic_pkg::DAMP_MAX)) begin
            s_d.cfg.damp = bpic_pkg::DAMP_MAX;
          end else begin
            s_d.cfg.damp = apb_req.pwdata[5:0];
          end
        end
        default: begin
          // Name and unit text, four bytes a word
          if (apb_req.paddr[7:4] == bpic_pkg::OFS_NAME[7:4]) begin
            s_d.name[apb_req.paddr[3:2]] = apb_req.pwdata;
          end else if (apb_req.paddr[7:4] == bpic_pkg::OFS_UNIT[7:4]) begin
            s_d.unit[apb_req.paddr[3:2]] = apb_req.pwdata;
          end
        end
      endcase
    end

    // Static level with polarity; pin taken as synchronous
    s_d.pin    = pin_in;
    s_d.active = s_q.cfg.en && (s_q.cfg.sig == bpic_pkg::SIG_STATIC) &&
                 (pin_in == s_q.cfg.pol);
    // Sampling held off while access input is inactive
    s_d.hold   = s_q.cfg.en && (s_q.cfg.sig == bpic_pkg::SIG_STATIC) &&
                 (pin_in != s_q.cfg.pol);

    // Edge counting over a fixed gate
    if (!pulse_on) begin
      s_d.gate  = '0;
      s_d.edges = '0;
      s_d.valid = 1'b0;
    end else if (gate_end) begin
      s_d.gate  = '0;
      s_d.edges = 27'(pin_in && !s_q.pin);  // Edge opens next gate
      s_d.freq  = freq_c;
    end else begin
      s_d.gate = 27'(s_q.gate + 27'h1);
      if (pin_in && !s_q.pin && (s_q.edges != '1)) begin
        s_d.edges = 27'(s_q.edges + 27'h1);
      end
    end

    // Scaling and damping sequence
    unique case (s_q.fsm)
      bpic_pkg::FSM_IDLE: begin
        // A gate ending mid-sequence is skipped; gate is far longer
        if (gate_end) begin
          if (s_q.cfg.mode == bpic_pkg::MODE_FREQ) begin
            s_d.scaled = freq_c;
            s_d.fsm    = bpic_pkg::FSM_DAMP;
          end else begin
            s_d.dvd    = 48'(64'(span) * 64'(freq_c));
            s_d.dsr    = s_q.cfg.fmax;
            s_d.div_go = 1'b1;
            s_d.fsm    = bpic_pkg::FSM_SCALE;
          end
        end
      end
      bpic_pkg::FSM_SCALE: begin
        if (div_done) begin
          s_d.scaled = 32'(s_q.cfg.lrv + div_q[31:0]);
          s_d.fsm    = bpic_pkg::FSM_DAMP;
        end
      end
      bpic_pkg::FSM_DAMP: begin
        if (s_q.cfg.damp == 6'h00) begin
          s_d.value = s_q.scaled;
          s_d.valid = pulse_on;
          s_d.fsm   = bpic_pkg::FSM_IDLE;
        end else begin
          // Ring of one-second samples, running window sum
          s_d.hist[s_q.wp] = s_q.scaled;
          s_d.wp  = 6'(s_q.wp + 6'h01);
          s_d.sum = sum_n;
          if (s_q.fill != s_q.cfg.damp) begin
            s_d.fill = 6'(s_q.fill + 6'h01);
          end
          s_d.neg    = sum_n[39];
          s_d.dvd    = sum_n[39] ? 48'(-$signed(sum_n)) : 48'(sum_n);
          s_d.dsr    = (s_q.fill != s_q.cfg.damp)
                     ? 32'(s_q.fill + 6'h01) : 32'(s_q.cfg.damp);
          s_d.div_go = 1'b1;
          s_d.fsm    = bpic_pkg::FSM_AVG;
        end
      end
      bpic_pkg::FSM_AVG: begin
        if (div_done) begin
          s_d.value = s_q.neg ? 32'(-div_q[31:0]) : div_q[31:0];
          s_d.valid = pulse_on;
          s_d.fsm   = bpic_pkg::FSM_IDLE;
        end
      end
    endcase
    // New window length restarts the average, over any damping step
    if (wr && (apb_req.paddr == bpic_pkg::OFS_DAMP)) begin
      s_d.fill = '0;
      s_d.sum  = '0;
    end
  end

  // ==========================================================
  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_q          <= '0;
      s_q.cfg.en   <= bpic_pkg::RST_EN;
      s_q.cfg.sig  <= bpic_pkg::SIG_STATIC;
      s_q.cfg.pol  <= bpic_pkg::RST_POL;
      s_q.cfg.mode <= bpic_pkg::MODE_FREQ;
      s_q.cfg.dec  <= bpic_pkg::RST_DEC;
      s_q.cfg.fmax <= bpic_pkg::FMAX_MAX;
      s_q.cfg.lrv  <= bpic_pkg::RST_RNG;
      s_q.cfg.urv  <= bpic_pkg::RST_RNG;
      s_q.cfg.damp <= bpic_pkg::RST_DAMP;
      s_q.fsm      <= bpic_pkg::FSM_IDLE;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign apb_rsp          = s_q.rsp;
  assign level_active_q   = s_q.active;
  assign sample_hold_q    = s_q.hold;
  assign value_q          = s_q.value;
  assign value_valid_q    = s_q.valid;
  assign value_decimals_q = s_q.cfg.dec;

  // ==========================================================
  // Checks
  a_enable_default: assert property (@(posedge clk_sys)
    $rose(rst_b) |-> s_q.cfg.en && s_q.cfg.pol)
    else $error("channel not enabled after reset");
  a_static_default: assert property (@(posedge clk_sys)
    $rose(rst_b) |-> s_q.cfg.sig == bpic_pkg::SIG_STATIC &&
      s_q.cfg.mode == bpic_pkg::MODE_FREQ && s_q.cfg.damp == 6'h00)
    else $error("wrong type or mode after reset");
  a_level_polarity: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    clk_en && s_q.cfg.en && s_q.cfg.sig == bpic_pkg::SIG_STATIC &&
      !wr ##1 clk_en |-> level_active_q == (s_q.pin == s_q.cfg.pol))
    else $error("active level does not follow polarity");
  a_hold_access: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    clk_en && s_q.cfg.en && s_q.cfg.sig == bpic_pkg::SIG_STATIC && !wr
      ##1 clk_en |-> sample_hold_q == (s_q.pin != s_q.cfg.pol))
    else $error("hold does not follow the access input");
  a_fmax_range: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    s_q.cfg.fmax >= bpic_pkg::FMAX_MIN && s_q.cfg.fmax <= bpic_pkg::FMAX_MAX)
    else $error("maximum frequency out of range");
  a_freq_clamp: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    $changed(s_q.freq) |-> s_q.freq <= $past(s_q.cfg.fmax))
    else $error("frequency above maximum");
  a_range_limits: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    $signed(s_q.cfg.lrv) >= $signed(bpic_pkg::LRV_MIN) &&
      $signed(s_q.cfg.lrv) <= 0 && s_q.cfg.urv <= bpic_pkg::URV_MAX)
    else $error("range value outside limits");
  a_freq_direct: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    clk_en && s_q.fsm == bpic_pkg::FSM_DAMP && s_q.cfg.damp == 6'h00 &&
      s_q.cfg.mode == bpic_pkg::MODE_FREQ && !wr |=> value_q == s_q.freq)
    else $error("frequency mode value differs from rate");
  a_scale_full: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    clk_en && s_q.fsm == bpic_pkg::FSM_SCALE && div_done &&
      s_q.freq == s_q.cfg.fmax && !wr |=> s_q.scaled == s_q.cfg.urv)
    else $error("full-scale rate not mapped to upper value");
  a_name_store: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    clk_en && wr && apb_req.paddr == bpic_pkg::OFS_NAME
      |=> s_q.name[0] == $past(apb_req.pwdata))
    else $error("name text not stored");

endmodule : bpic_channel

// ---- testbench/bpic_pulse_src.sv ----
`timescale 1ns/100ps
// ==========================================================
// Far side: steady switch level or flowmeter pulse train
module bpic_pulse_src (
  input  wire logic        clk_sys,
  input  wire logic [15:0] half_per,
  input  wire logic        level,
  output logic             pin_in
);
  logic [15:0] cnt_q = 16'h0;  // Half-period counter
  logic        tog_q = 1'b0;   // Pulse phase
  logic        wrap;           // Half period complete
  assign wrap = (cnt_q + 16'h1) >= half_per;
  // Free-running train, so pulses keep coming across gate ends
  always_ff @(posedge clk_sys) begin
    cnt_q <= wrap ? 16'h0 : cnt_q + 16'h1;
    if (wrap) tog_q <= ~tog_q;
  end
  // Zero half period means a switch held at one level
  assign pin_in = (half_per == 16'h0) ? level : tog_q;
endmodule : bpic_pulse_src

// ---- testbench/binary_pulse_input_channel_tb.sv ----
`timescale 1ns/100ps
module binary_pulse_input_channel_tb;
  // ==========================================================
  // Signals
  logic                       clk_sys;   // System clock
  logic                       rst_b;     // Reset, active low
  bpic_pkg::bpic_apb_req_type req;       // Bus request
  bpic_pkg::bpic_apb_rsp_type rsp;       // Bus answer
  logic                       pin;       // Input pin
  logic                       act;       // Level active
  logic                       hold;      // Sample hold
  logic [31:0]                val;       // Process value
  logic                       vld;       // Value valid
  logic [1:0]                 dec;       // Decimal places
  logic [15:0]                half_per;  // Pulse half period
  logic                       level;     // Switch level
  logic [31:0]                rd;        // Read data
  logic                       err;       // Bus error
  int                         failures;  // Mismatch count
  int                         checked;   // Comparison count
  int                         cyc = 0;   // Timeout counter
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d, x; logic e;}
    bpic_row_type;                       // Access, expected, error
  bpic_row_type               rows[16];  // Register table
  // ==========================================================
  // Clock, short gate keeps the run brief
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  bpic_channel #(.GATE_CYCLES(1000)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .clk_en(1'b1), .apb_req(req), .apb_rsp(rsp), .pin_in(pin),
    .level_active_q(act), .sample_hold_q(hold), .value_q(val),
    .value_valid_q(vld), .value_decimals_q(dec));
  bpic_pulse_src src (.clk_sys(clk_sys), .half_per(half_per),
    .level(level), .pin_in(pin));
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; answer taken where pready stands high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do @(posedge clk_sys); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  // Fixed wait counted in clock cycles, then settle
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : wait_cyc
  task automatic give_verdict;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Hang guard, well above the expected 13700 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      give_verdict();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    failures = 0;
    checked = 0;
    req = '0; rst_b = 1'b0; half_per = 16'h0; level = 1'b0;
    rows = '{'{0, 8'h00, 0, 32'h0000_0205, 0},  // Reset control word
             '{0, 8'h04, 0, 32'h0001_86A0, 0},  // Full-scale 1000.00
             '{0, 8'h08, 0, 32'h0000_0000, 0},
             '{0, 8'h0C, 0, 32'h0000_0000, 0},
             '{0, 8'h10, 0, 32'h0000_0000, 0},
             '{1, 8'h04, 32'h0000_0001, 32'h0000_2710, 0},  // Below 100.00
             '{1, 8'h04, 32'h00FF_FFFF, 32'h0001_86A0, 0},
             '{1, 8'h08, 32'hFFF0_0000, 32'hFFFC_F2C0, 0},
             '{1, 8'h0C, 32'h7FFF_FFFF, 32'h000F_4240, 0},
             '{1, 8'h10, 32'h0000_0064, 32'h0000_003C, 0},
             '{1, 8'h20, 32'h4142_4344, 32'h4142_4344, 0},  // Name text
             '{1, 8'h3C, 32'h6850_6100, 32'h6850_6100, 0},  // Unit text
             '{1, 8'h00, 32'h0000_0235, 32'h0000_0205, 0},  // Mode 3 kept out
             '{1, 8'h14, 32'hFFFF_FFFF, 32'h0000_0002, 0},  // Status read only
             '{0, 8'h40, 0, 32'h0000_0000, 1},              // Unmapped
             '{0, 8'h02, 0, 32'h0000_0000, 1}};             // Misaligned
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    check({30'h0, dec}, 32'h2);
    // Table: write when asked, read back, compare
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      if (!rows[i].e) begin
        check(rd, rows[i].x);
      end
      check({31'h0, err}, {31'h0, rows[i].e});
    end
    // Static level, both polarities, then disabled
    @(posedge clk_sys); level <= 1'b1;
    wait_cyc(3);
    check({act, hold}, 2'b10);
    @(posedge clk_sys); level <= 1'b0;
    wait_cyc(3);
    check({act, hold}, 2'b01);
    apb(1'b1, 8'h00, 32'h0000_0201);
    wait_cyc(3);
    check({act, hold}, 2'b10);
    apb(1'b1, 8'h00, 32'h0000_0200);
    wait_cyc(3);
    check({act, hold}, 2'b00);
    // Pulse rate: 50 edges per gate gives 50.00, damping off
    apb(1'b1, 8'h10, 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0001_86A0);
    @(posedge clk_sys); half_per <= 16'd10;
    apb(1'b1, 8'h00, 32'h0000_0203);
    wait_cyc(2500);
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h0000_1388);
    check(val, 32'h0000_1388);
    check({act, hold, vld}, 3'b001);
    // Rate above 100.00 maximum is clamped
    apb(1'b1, 8'h04, 32'h0000_2710);
    @(posedge clk_sys); half_per <= 16'd2;
    wait_cyc(2500);
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h0000_2710);
    // Parameter mode, -1000.00 to 1000.00 over 1000.00 Hz
    apb(1'b1, 8'h04, 32'h0001_86A0);
    apb(1'b1, 8'h08, 32'hFFFE_7960);
    apb(1'b1, 8'h0C, 32'h0001_86A0);
    @(posedge clk_sys); half_per <= 16'd10;
    apb(1'b1, 8'h00, 32'h0000_0213);
    wait_cyc(2500);
    check(val, 32'hFFFE_A070);
    // Flow mode, two-gate damping, three decimals
    apb(1'b1, 8'h00, 32'h0000_0323);
    apb(1'b1, 8'h10, 32'h0000_0002);
    wait_cyc(3500);
    check(val, 32'hFFFE_A070);
    check({30'h0, dec}, 32'h3);
    // Clamped full-scale rate lands on the upper value
    apb(1'b1, 8'h10, 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0000_2710);
    @(posedge clk_sys);
    half_per <= 16'd2;
    wait_cyc(2500);
    check(val, 32'h0001_86A0);
    // Mid-run reset brings back every default
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    check({27'h0, vld, act, hold, dec}, 32'h2);
    check(val, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0000_0205);
    give_verdict();
  end
endmodule : binary_pulse_input_channel_tb
